// ### src/krlt_train_ctrl.sv
// Link training control register bank and its command logic
//
// Functional notes
// RULE1: Main-tap step count sets steps per main tap update, range 1 to 15, reset 1.
// RULE2: Pre/post step count sets steps per pre- and post-tap update, reset 1.
// RULE3: Hysteresis code maps 0..7 to 0,2,4,8,16,32,64,128 added to error count, reset 32.
// RULE4: With no-reinit set, PMA values stay unchanged on training failure entry, else reinit.
// RULE5: With remote override set, software update commands go to the partner, else engine's.
// RULE6: With local override set, software sets local coefficients, else partner commands do.
// RULE7: Amplitude training bit exercises or skips partner main-tap adjustment, reset skip.
// RULE8: Feedback equalizer bypass at end of training when 1, enabled when 0, reset per build.
// RULE9: Freeze mode 00 freezes no taps, 01 all, others reserved, reset 01, only when not bypassed.
// RULE10: Adaptation mode 0 sweeps linear equalizer first, 1 uses fixed manual values.
// RULE11: Manual linear equalizer value applies only in manual mode, reset 1.
// RULE12: Manual gain value applies only in manual mode, reset 4 in simulation, 7 in hardware.
// RULE13: Writing 1 to restart resets the training protocol and the bit self-clears.
// RULE14: New-remote command sends the remote coefficient byte to the partner, needs override.
// RULE15: New-local command applies the local coefficient byte, needs local override.
// RULE16: Control bit 0 enables the training protocol, reset enabled.
// RULE17: Writing 0 to a command bit does nothing and command bits read 0 once accepted.
`timescale 1ns/100ps
`include "krlt_regs.svh"
module krlt_train_ctrl #(
  parameter bit SIM_DEFAULTS = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`KRLT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic train_fail_entry,
  input wire logic [7:0] lt_remote_cmd,
  input wire logic remote_cmd_ack,
  input wire logic [7:0] rx_update_cmd,
  input wire logic rx_update_valid,
  output logic lt_enable,
  output logic lt_restart,
  output logic [3:0] main_step,
  output logic [3:0] prepost_step,
  output logic [7:0] hyst_count,
  output logic pma_reinit,
  output logic remote_cmd_sw,
  output logic [7:0] remote_cmd,
  output logic remote_cmd_valid,
  output logic [7:0] local_coef,
  output logic local_coef_load,
  output logic amplitude_training_en,
  output logic dfe_bypass,
  output logic dfe_freeze_all,
  output logic ctle_sweep_en,
  output logic [4:0] ctle_manual_value,
  output logic [2:0] vga_manual_value
);
  // Strobes and read-back words between the bus front end and the bank
  krlt_regbus_if rb ();

  // Control word fields
  logic lt_en_r;
  logic [3:0] main_cnt_r;
  logic [3:0] pp_cnt_r;
  logic [2:0] hyst_code_r;
  logic no_reinit_r;
  logic remote_coef_override;
  logic loc_ovr_r;
  logic amp_en_r;
  logic dfe_byp_r;
  logic [1:0] frz_mode_r;
  logic ctle_mode_r;
  logic [4:0] ctle_val_r;
  logic [2:0] vga_val_r;

  // Coefficient bytes
  krlt_pkg::krlt_coef_t rem_coef_r;
  krlt_pkg::krlt_coef_t loc_coef_sw_r;

  // Registered outputs
  logic lt_enable_r;
  logic [3:0] main_step_r;
  logic [3:0] prepost_step_r;
  logic [7:0] hyst_count_r;
  logic pma_reinit_r;
  logic remote_cmd_sw_r;
  krlt_pkg::krlt_coef_t remote_cmd_r;
  logic remote_cmd_valid_r;
  krlt_pkg::krlt_coef_t local_coef_r;
  logic local_coef_load_r;
  logic amp_out_r;
  logic dfe_bypass_r;
  logic dfe_freeze_all_r;
  logic ctle_sweep_en_r;
  logic [4:0] ctle_manual_value_r;
  logic [2:0] vga_manual_value_r;
  logic lt_restart_r;

  krlt_pkg::krlt_rem_state_t rem_state_r;
  krlt_pkg::krlt_rem_state_t rem_state_nxt;

  logic [`KRLT_NCMD-1:0] cmd_pulse;

  // Reset values that differ between simulation and hardware builds
  localparam logic DFE_BYP_RST = SIM_DEFAULTS;
  localparam logic CTLE_MODE_RST = SIM_DEFAULTS;
  localparam logic [2:0] VGA_RST = SIM_DEFAULTS ? `KRLT_RST_VGA_SIM : `KRLT_RST_VGA_HW;

  // Hysteresis code to error-count offset, code 0 adds nothing
  function automatic logic [7:0] hyst_decode(input logic [2:0] code);
    hyst_decode = (code == 3'h0) ? 8'h00 : (8'h01 << code);
  endfunction : hyst_decode

  function automatic logic [3:0] step_clamp(input logic [3:0] cnt);
    step_clamp = (cnt < `KRLT_MIN_STEP) ? `KRLT_MIN_STEP : cnt;
  endfunction : step_clamp

  krlt_apb_slave u_apb (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rb(rb)
  );

  // Command bits of the command word, one pulse each
  wire [`KRLT_NCMD-1:0] cmd_set = {rb.wdata[`KRLT_C_NEW_LOC], rb.wdata[`KRLT_C_NEW_REM],
    rb.wdata[`KRLT_C_RESTART]};

  krlt_cmd_pulse u_cmd (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr(rb.wr_cmd),
    .set_bits(cmd_set),
    .pulse(cmd_pulse)
  );

  wire restart_cmd = cmd_pulse[0];
  wire new_rem_cmd = cmd_pulse[1];
  wire new_loc_cmd = cmd_pulse[2];
  wire [31:0] wd = rb.wdata;

  // Read-back words, reserved bits read zero
  assign rb.rd_ctrl = {vga_val_r, ctle_val_r, 1'b0, ctle_mode_r, frz_mode_r, dfe_byp_r,
    amp_en_r, loc_ovr_r, remote_coef_override, no_reinit_r, hyst_code_r, pp_cnt_r,
    main_cnt_r, 3'h0, lt_en_r};
  assign rb.rd_cmd = {23'h000000, new_loc_cmd, 3'h0, new_rem_cmd, 3'h0, restart_cmd}; // RULE17
  assign rb.rd_coef = {8'h00, loc_coef_sw_r, 8'h00, rem_coef_r};

  // Control word storage
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      lt_en_r <= 1'b1; // RULE16
      main_cnt_r <= `KRLT_RST_STEP; // RULE1
      pp_cnt_r <= `KRLT_RST_STEP; // RULE2
      hyst_code_r <= `KRLT_RST_HYST; // RULE3
      no_reinit_r <= 1'b0;
      remote_coef_override <= 1'b0;
      loc_ovr_r <= 1'b0;
      amp_en_r <= 1'b0; // RULE7
      dfe_byp_r <= DFE_BYP_RST; // RULE8
      frz_mode_r <= `KRLT_RST_FRZ; // RULE9
      ctle_mode_r <= CTLE_MODE_RST; // RULE10
      ctle_val_r <= `KRLT_RST_CTLE; // RULE11
      vga_val_r <= VGA_RST; // RULE12
    end
    else if (rb.wr_ctrl)
    begin
      lt_en_r <= wd[`KRLT_F_LT_EN];
      main_cnt_r <= wd[`KRLT_F_MAIN_MSB:`KRLT_F_MAIN_LSB];
      pp_cnt_r <= wd[`KRLT_F_PP_MSB:`KRLT_F_PP_LSB];
      hyst_code_r <= wd[`KRLT_F_HYST_MSB:`KRLT_F_HYST_LSB];
      no_reinit_r <= wd[`KRLT_F_NOREINIT];
      remote_coef_override <= wd[`KRLT_F_REM_OVR];
      loc_ovr_r <= wd[`KRLT_F_LOC_OVR];
      amp_en_r <= wd[`KRLT_F_AMP_EN];
      dfe_byp_r <= wd[`KRLT_F_DFE_BYP];
      frz_mode_r <= wd[`KRLT_F_FRZ_MSB:`KRLT_F_FRZ_LSB];
      ctle_mode_r <= wd[`KRLT_F_CTLE_MODE];
      ctle_val_r <= wd[`KRLT_F_CTLE_MSB:`KRLT_F_CTLE_LSB];
      vga_val_r <= wd[`KRLT_F_VGA_MSB:`KRLT_F_VGA_LSB];
    end
  end

  // Coefficient byte storage
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rem_coef_r <= 8'h00;
      loc_coef_sw_r <= 8'h00;
    end
    else if (rb.wr_coef)
    begin
      rem_coef_r <= wd[`KRLT_K_REM_MSB:`KRLT_K_REM_LSB];
      loc_coef_sw_r <= wd[`KRLT_K_LOC_MSB:`KRLT_K_LOC_LSB];
    end
  end

  // Settings handed to the training engine
  // A zero step count shows as one so the engine never stalls
  wire [3:0] main_step_nxt = step_clamp(main_cnt_r); // RULE1
  wire [3:0] prepost_step_nxt = step_clamp(pp_cnt_r); // RULE2
  wire [7:0] hyst_nxt = hyst_decode(hyst_code_r); // RULE3
  // Reserved freeze codes act as no freeze
  wire freeze_nxt = ~dfe_byp_r & (frz_mode_r == `KRLT_FRZ_ALL); // RULE9
  wire [4:0] ctle_nxt = ctle_mode_r ? ctle_val_r : 5'h00; // RULE11
  wire [2:0] vga_nxt = ctle_mode_r ? vga_val_r : 3'h0; // RULE12
  wire reinit_nxt = train_fail_entry & ~no_reinit_r; // RULE4

  // One cycle from field to pin, every output from a flip-flop
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      lt_enable_r <= 1'b1;
      main_step_r <= `KRLT_RST_STEP;
      prepost_step_r <= `KRLT_RST_STEP;
      hyst_count_r <= 8'h00;
      pma_reinit_r <= 1'b0;
      amp_out_r <= 1'b0;
      dfe_bypass_r <= DFE_BYP_RST;
      dfe_freeze_all_r <= 1'b0;
      ctle_sweep_en_r <= 1'b0;
      ctle_manual_value_r <= 5'h00;
      vga_manual_value_r <= 3'h0;
      lt_restart_r <= 1'b0;
    end
    else
    begin
      lt_enable_r <= lt_en_r; // RULE16
      main_step_r <= main_step_nxt;
      prepost_step_r <= prepost_step_nxt;
      hyst_count_r <= hyst_nxt;
      pma_reinit_r <= reinit_nxt; // RULE4
      amp_out_r <= amp_en_r; // RULE7
      dfe_bypass_r <= dfe_byp_r; // RULE8
      dfe_freeze_all_r <= freeze_nxt;
      ctle_sweep_en_r <= ~ctle_mode_r; // RULE10
      ctle_manual_value_r <= ctle_nxt;
      vga_manual_value_r <= vga_nxt;
      lt_restart_r <= restart_cmd; // RULE13
    end
  end

  // Remote command path: software byte held until the partner side takes it
  // A pending byte is dropped on ack, on override clear or on restart
  wire rem_start = new_rem_cmd & remote_coef_override; // RULE14
  wire rem_drop = remote_cmd_ack | ~remote_coef_override | restart_cmd;
  always_comb
  begin
    rem_state_nxt = rem_state_r;
    case (rem_state_r)
      krlt_pkg::KRLT_REM_IDLE:
      begin
        if (rem_start) // RULE14
          rem_state_nxt = krlt_pkg::KRLT_REM_SEND;
      end
      krlt_pkg::KRLT_REM_SEND:
      begin
        if (rem_drop)
          rem_state_nxt = krlt_pkg::KRLT_REM_IDLE;
      end
      default:
      begin
        rem_state_nxt = krlt_pkg::KRLT_REM_IDLE;
      end
    endcase
  end

  wire rem_load = (rem_state_r == krlt_pkg::KRLT_REM_IDLE) & rem_start;
  // Engine byte passes through while software does not own the partner taps
  wire [7:0] remote_cmd_nxt = ~remote_coef_override ? lt_remote_cmd : // RULE5
    rem_load ? rem_coef_r : remote_cmd_r;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rem_state_r <= krlt_pkg::KRLT_REM_IDLE;
      remote_cmd_r <= 8'h00;
      remote_cmd_sw_r <= 1'b0;
      remote_cmd_valid_r <= 1'b0;
    end
    else
    begin
      rem_state_r <= rem_state_nxt;
      remote_cmd_r <= remote_cmd_nxt;
      remote_cmd_sw_r <= remote_coef_override; // RULE5
      remote_cmd_valid_r <= (rem_state_nxt == krlt_pkg::KRLT_REM_SEND); // RULE14
    end
  end

  // Local coefficient path
  // Partner updates are ignored while software owns the local taps
  wire loc_from_sw = loc_ovr_r & new_loc_cmd; // RULE15
  wire loc_from_lp = ~loc_ovr_r & rx_update_valid; // RULE6
  wire [7:0] local_coef_nxt = loc_from_sw ? loc_coef_sw_r :
    loc_from_lp ? rx_update_cmd : local_coef_r;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      local_coef_r <= 8'h00;
      local_coef_load_r <= 1'b0;
    end
    else
    begin
      local_coef_r <= local_coef_nxt; // RULE6
      local_coef_load_r <= loc_from_sw | loc_from_lp;
    end
  end

  assign lt_enable = lt_enable_r;
  assign lt_restart = lt_restart_r;
  assign main_step = main_step_r;
  assign prepost_step = prepost_step_r;
  assign hyst_count = hyst_count_r;
  assign pma_reinit = pma_reinit_r;
  assign remote_cmd_sw = remote_cmd_sw_r;
  assign remote_cmd = remote_cmd_r;
  assign remote_cmd_valid = remote_cmd_valid_r;
  assign local_coef = local_coef_r;
  assign local_coef_load = local_coef_load_r;
  assign amplitude_training_en = amp_out_r;
  assign dfe_bypass = dfe_bypass_r;
  assign dfe_freeze_all = dfe_freeze_all_r;
  assign ctle_sweep_en = ctle_sweep_en_r;
  assign ctle_manual_value = ctle_manual_value_r;
  assign vga_manual_value = vga_manual_value_r;
endmodule : krlt_train_ctrl

// ### src/krlt_regs.svh
// Register indices, field positions and reset values of the training control bank
`ifndef KRLT_REGS_SVH
`define KRLT_REGS_SVH

`define KRLT_ADDR_W 16
`define KRLT_IDX_W 12
`define KRLT_IDX_CTRL 12'h4D0
`define KRLT_IDX_CMD 12'h4D1
`define KRLT_IDX_COEF 12'h4D4

`define KRLT_F_LT_EN 0
`define KRLT_F_MAIN_LSB 4
`define KRLT_F_MAIN_MSB 7
`define KRLT_F_PP_LSB 8
`define KRLT_F_PP_MSB 11
`define KRLT_F_HYST_LSB 12
`define KRLT_F_HYST_MSB 14
`define KRLT_F_NOREINIT 15
`define KRLT_F_REM_OVR 16
`define KRLT_F_LOC_OVR 17
`define KRLT_F_AMP_EN 18
`define KRLT_F_DFE_BYP 19
`define KRLT_F_FRZ_LSB 20
`define KRLT_F_FRZ_MSB 21
`define KRLT_F_CTLE_MODE 22
`define KRLT_F_CTLE_LSB 24
`define KRLT_F_CTLE_MSB 28
`define KRLT_F_VGA_LSB 29
`define KRLT_F_VGA_MSB 31

`define KRLT_C_RESTART 0
`define KRLT_C_NEW_REM 4
`define KRLT_C_NEW_LOC 8
`define KRLT_K_REM_LSB 0
`define KRLT_K_REM_MSB 7
`define KRLT_K_LOC_LSB 16
`define KRLT_K_LOC_MSB 23

`define KRLT_RST_STEP 4'h1
`define KRLT_RST_HYST 3'h5
`define KRLT_RST_FRZ 2'h1
`define KRLT_RST_CTLE 5'h01
`define KRLT_RST_VGA_SIM 3'h4
`define KRLT_RST_VGA_HW 3'h7
`define KRLT_FRZ_ALL 2'h1
`define KRLT_MIN_STEP 4'h1
`define KRLT_NCMD 3

`endif

// ### src/krlt_pkg.sv
// Shared types of the training control bank
package krlt_pkg;
  typedef enum logic [1:0]
  {
    KRLT_REM_IDLE = 2'b01,
    KRLT_REM_SEND = 2'b10
  } krlt_rem_state_t;
  typedef logic [7:0] krlt_coef_t;
endpackage : krlt_pkg

// ### src/krlt_regbus_if.sv
// Internal register strobe and read-back bundle
`timescale 1ns/100ps
interface krlt_regbus_if;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_coef;
  logic [31:0] wdata;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_cmd;
  logic [31:0] rd_coef;
  modport bus (output wr_ctrl, output wr_cmd, output wr_coef, output wdata,
    input rd_ctrl, input rd_cmd, input rd_coef);
  modport regs (input wr_ctrl, input wr_cmd, input wr_coef, input wdata,
    output rd_ctrl, output rd_cmd, output rd_coef);
endinterface : krlt_regbus_if

// ### src/krlt_apb_slave.sv
// APB slave front end with word index decode
`timescale 1ns/100ps
`include "krlt_regs.svh"
module krlt_apb_slave (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`KRLT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  krlt_regbus_if.bus rb
);
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  function automatic logic idx_hit(input logic [`KRLT_ADDR_W-1:0] a,
    input logic [`KRLT_IDX_W-1:0] idx);
    idx_hit = (a == {2'b00, idx, 2'b00});
  endfunction : idx_hit

  wire hit_ctrl = idx_hit(paddr, `KRLT_IDX_CTRL);
  wire hit_cmd = idx_hit(paddr, `KRLT_IDX_CMD);
  wire hit_coef = idx_hit(paddr, `KRLT_IDX_COEF);
  wire mapped = hit_ctrl | hit_cmd | hit_coef;
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pready_r & pwrite & mapped;
  wire [31:0] rd_mux = hit_ctrl ? rb.rd_ctrl : hit_cmd ? rb.rd_cmd :
    hit_coef ? rb.rd_coef : 32'h0000_0000;

  assign rb.wr_ctrl = wr_acc & hit_ctrl;
  assign rb.wr_cmd = wr_acc & hit_cmd;
  assign rb.wr_coef = wr_acc & hit_coef;
  assign rb.wdata = pwdata;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // One wait-free access phase after each setup
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule : krlt_apb_slave

// ### src/krlt_cmd_pulse.sv
// Self-clearing command bits
`timescale 1ns/100ps
`include "krlt_regs.svh"
module krlt_cmd_pulse (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr,
  input wire logic [`KRLT_NCMD-1:0] set_bits,
  output logic [`KRLT_NCMD-1:0] pulse
);
  genvar i;
  generate
    for (i = 0; i < `KRLT_NCMD; i = i + 1)
    begin : g_cmd
      logic cmd_r;
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
          cmd_r <= 1'b0;
        else
          cmd_r <= wr & set_bits[i]; // RULE17
      end
      assign pulse[i] = cmd_r;
    end
  endgenerate
endmodule : krlt_cmd_pulse

// ### dv/krlt_checker.sv
// Port assertions of the training control bank
`timescale 1ns/100ps
module krlt_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic train_fail_entry,
  input wire logic remote_cmd_ack,
  input wire logic lt_restart,
  input wire logic [3:0] main_step,
  input wire logic [3:0] prepost_step,
  input wire logic [7:0] hyst_count,
  input wire logic pma_reinit,
  input wire logic remote_cmd_sw,
  input wire logic remote_cmd_valid,
  input wire logic ctle_sweep_en,
  input wire logic [4:0] ctle_manual_value,
  input wire logic [2:0] vga_manual_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_PRDY: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_PERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  AST_STEP: assert property (main_step != 4'h0 && prepost_step != 4'h0)
    else $error("step count zero");
  AST_HYST: assert property (hyst_count == 8'h00 ||
    ($onehot(hyst_count) && !hyst_count[0]))
    else $error("hysteresis not in table");
  AST_REIN: assert property (pma_reinit |-> $past(train_fail_entry))
    else $error("reinit without failure entry");
  AST_RSTP: assert property (lt_restart |=> !lt_restart)
    else $error("restart longer than one cycle");
  AST_RACK: assert property (remote_cmd_valid && remote_cmd_ack |=> !remote_cmd_valid)
    else $error("command pending after ack");
  AST_RSW: assert property ($rose(remote_cmd_valid) |-> remote_cmd_sw)
    else $error("command sent without override");
  AST_MAN: assert property (ctle_sweep_en |->
    ctle_manual_value == 5'h00 && vga_manual_value == 3'h0)
    else $error("manual values outside manual mode");
endmodule : krlt_checker

bind krlt_train_ctrl krlt_checker u_chk (.clk_sys, .sys_rst, .psel, .penable, .prdata, .pready,
  .pslverr, .train_fail_entry, .remote_cmd_ack, .lt_restart, .main_step, .prepost_step,
  .hyst_count, .pma_reinit, .remote_cmd_sw, .remote_cmd_valid, .ctle_sweep_en,
  .ctle_manual_value, .vga_manual_value);

// ### dv/krlt_lp_model.sv
// Link partner model: takes software commands and sends update commands
`timescale 1ns/100ps
module krlt_lp_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic remote_cmd_valid,
  input wire logic [7:0] remote_cmd,
  input wire logic [3:0] ack_delay,
  input wire logic send,
  input wire logic [7:0] send_val,
  output logic remote_cmd_ack,
  output logic rx_update_valid,
  output logic [7:0] rx_update_cmd,
  output logic [7:0] last_cmd
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_r <= 4'h0;
      remote_cmd_ack <= 1'b0;
      rx_update_valid <= 1'b0;
      rx_update_cmd <= 8'h00;
      last_cmd <= 8'h00;
    end
    else
    begin
      remote_cmd_ack <= 1'b0;
      if (remote_cmd_valid && !remote_cmd_ack)
      begin
        cnt_r <= (cnt_r == ack_delay) ? 4'h0 : cnt_r + 4'h1;
        remote_cmd_ack <= (cnt_r == ack_delay);
        if (cnt_r == ack_delay)
          last_cmd <= remote_cmd;
      end
      rx_update_valid <= send;
      // Released data toggles so stale values never look valid
      rx_update_cmd <= send ? send_val : ~rx_update_cmd;
    end
  end
endmodule : krlt_lp_model

// ### dv/krlt_train_ctrl_tb.sv
// Register and command bench of the training control bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) fail_cmp(n, e, g); end
module krlt_train_ctrl_tb;
  localparam logic [31:0] CTRL_RST = 32'hE1105111;
  localparam logic [15:0] A_CTRL = 16'h1340;
  localparam logic [15:0] A_CMD = 16'h1344;
  localparam logic [15:0] A_COEF = 16'h1350;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, train_fail_entry = 1'b0, send = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd_v, v;
  logic [7:0] lt_remote_cmd = 8'h00, send_val = 8'h00, rx_update_cmd, remote_cmd, local_coef;
  logic [7:0] last_cmd, hyst_count;
  logic [3:0] ack_delay = 4'hC, main_step, prepost_step;
  logic [4:0] ctle_manual_value;
  logic [2:0] vga_manual_value;
  logic pready, pslverr, er_v, remote_cmd_ack, rx_update_valid, lt_enable, lt_restart;
  logic pma_reinit, remote_cmd_sw, remote_cmd_valid, local_coef_load, amplitude_training_en;
  logic dfe_bypass, dfe_freeze_all, ctle_sweep_en;
  logic s_byp, s_swp;
  logic [4:0] s_ctle;
  logic [2:0] s_vga;
  int err_count = 0, total_checks = 0, n_rst = 0, n_ld = 0, n_pma = 0;

  krlt_train_ctrl #(.SIM_DEFAULTS(1'b0)) DUT (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .train_fail_entry, .lt_remote_cmd,
    .remote_cmd_ack, .rx_update_cmd, .rx_update_valid, .lt_enable, .lt_restart, .main_step,
    .prepost_step, .hyst_count, .pma_reinit, .remote_cmd_sw, .remote_cmd, .remote_cmd_valid,
    .local_coef, .local_coef_load, .amplitude_training_en, .dfe_bypass, .dfe_freeze_all,
    .ctle_sweep_en, .ctle_manual_value, .vga_manual_value);
  krlt_lp_model u_lp (.clk_sys, .sys_rst, .remote_cmd_valid, .remote_cmd, .ack_delay, .send,
    .send_val, .remote_cmd_ack, .rx_update_valid, .rx_update_cmd, .last_cmd);
  // Second bank built with simulation reset values
  krlt_train_ctrl #(.SIM_DEFAULTS(1'b1)) DUT_SIM (.clk_sys, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .train_fail_entry,
    .lt_remote_cmd, .remote_cmd_ack, .rx_update_cmd, .rx_update_valid, .lt_enable(),
    .lt_restart(), .main_step(), .prepost_step(), .hyst_count(), .pma_reinit(),
    .remote_cmd_sw(), .remote_cmd(), .remote_cmd_valid(), .local_coef(), .local_coef_load(),
    .amplitude_training_en(), .dfe_bypass(s_byp), .dfe_freeze_all(), .ctle_sweep_en(s_swp),
    .ctle_manual_value(s_ctle), .vga_manual_value(s_vga));

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    n_rst <= n_rst + (lt_restart === 1'b1);
    n_ld <= n_ld + (local_coef_load === 1'b1);
    n_pma <= n_pma + (pma_reinit === 1'b1);
  end

  task fail_cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    err_count++;
    $display("MISMATCH %s exp %0h got %0h", n, e, g);
  endtask : fail_cmp

  task summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      summarize();
    end
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task settle;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task pulse_in(input logic is_send, input logic [7:0] val);
    @(posedge clk_sys);
    send_val <= val;
    if (is_send) send <= 1'b1; else train_fail_entry <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    train_fail_entry <= 1'b0;
    settle();
  endtask : pulse_in

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    apb(1'b0, A_CTRL, 32'h0);
    `CHK("ctrl reset", CTRL_RST, rd_v)
    v = {lt_enable, ctle_sweep_en, dfe_freeze_all, hyst_count[5], dfe_bypass, vga_manual_value,
      ctle_manual_value};
    `CHK("reset outs", 32'h00001E00, v)
    v = {s_byp, s_swp, s_vga, s_ctle};
    `CHK("sim reset outs", 32'h00000281, v)
    for (int i = 0; i < 8; i++)
    begin
      v = 32'(i) << 12 | 32'(i * 2) << 4 | 32'(15 - i) << 8 | 32'(i % 2);
      apb(1'b1, A_CTRL, v);
      settle();
      `CHK("hyst", (i == 0) ? 8'h00 : 8'h01 << i, hyst_count)
      `CHK("main", (i == 0) ? 4'h1 : 4'(i * 2), main_step)
      `CHK("prepost", 4'(15 - i), prepost_step)
      `CHK("enable", 1'(i % 2), lt_enable)
      apb(1'b0, A_CTRL, 32'h0);
      `CHK("ctrl rb", v, rd_v)
    end
    for (int k = 0; k < 8; k++)
    begin
      v = 32'h6A400001 | 32'(k % 2) << 18 | 32'(k / 4) << 19 | 32'(k % 4) << 20;
      apb(1'b1, A_CTRL, v);
      settle();
      `CHK("amp", 1'(k % 2), amplitude_training_en)
      `CHK("bypass", 1'(k / 4), dfe_bypass)
      `CHK("freeze", 1'b0, dfe_freeze_all & dfe_bypass)
      `CHK("freeze on", (k / 4 == 0) && (k % 4 == 1), dfe_freeze_all)
      v = {ctle_sweep_en, vga_manual_value, ctle_manual_value};
      `CHK("manual", 32'h0000006A, v)
    end
    apb(1'b1, A_CTRL, CTRL_RST);
    pulse_in(1'b0, 8'h00);
    `CHK("reinit", 1, n_pma)
    apb(1'b1, A_CTRL, CTRL_RST | 32'h8000);
    pulse_in(1'b0, 8'h00);
    `CHK("no reinit", 1, n_pma)
    apb(1'b1, A_CMD, 32'h1);
    settle();
    `CHK("restart", 1, n_rst)
    apb(1'b0, A_CMD, 32'h0);
    `CHK("cmd rb", 32'h0, rd_v)
    apb(1'b1, A_CMD, 32'h0);
    settle();
    `CHK("zero cmd", 1, n_rst)
    @(posedge clk_sys);
    lt_remote_cmd <= 8'h5A;
    apb(1'b1, A_COEF, 32'h00C300A5);
    apb(1'b1, A_CMD, 32'h10);
    settle();
    `CHK("engine cmd", 10'h05A, {remote_cmd_sw, remote_cmd_valid, remote_cmd})
    apb(1'b1, A_CTRL, CTRL_RST | 32'h10000);
    apb(1'b1, A_CMD, 32'h10);
    settle();
    `CHK("sw cmd", 10'h3A5, {remote_cmd_sw, remote_cmd_valid, remote_cmd})
    repeat (15) @(posedge clk_sys);
    ack_delay <= 4'h0;
    settle();
    `CHK("acked", 9'h0A5, {remote_cmd_valid, last_cmd})
    pulse_in(1'b1, 8'h3C);
    `CHK("rx coef", 9'h13C, {n_ld[0], local_coef})
    apb(1'b1, A_CMD, 32'h100);
    settle();
    `CHK("loc refused", 1, n_ld)
    apb(1'b1, A_CTRL, CTRL_RST | 32'h20000);
    apb(1'b1, A_CMD, 32'h100);
    settle();
    pulse_in(1'b1, 8'h11);
    `CHK("loc coef", 10'h2C3, {n_ld[1:0], local_coef})
    apb(1'b0, A_COEF, 32'h0);
    `CHK("coef rb", 32'h00C300A5, rd_v)
    apb(1'b0, 16'h1348, 32'h0);
    `CHK("unmapped", 33'h100000000, {er_v, rd_v})
    apb(1'b1, 16'h1342, 32'h0);
    `CHK("unaligned err", 1'b1, er_v)
    apb(1'b0, A_CTRL, 32'h0);
    `CHK("no write", CTRL_RST | 32'h20000, rd_v)
    summarize();
  end
endmodule : krlt_train_ctrl_tb
